//--- debug_adapter.sv
// Behavioural debug adapter on the reset and serial debug clock pins.
// Assumes clk is the device system clock; the adapter also owns the supply,
// so it drives the power-on reset level as well.
`timescale 1ns/10ps

module debug_adapter
(
    input  wire logic clk,
    output logic      swclk,
    output logic      ext_reset_n,
    output logic      por_active
);
    // ------------------------------------------------------------------
    // Power-up state
    // ------------------------------------------------------------------
    // Supply ramping, reset driven low, clock pad pulled up
    initial
    begin
        swclk       = 1'b1;
        ext_reset_n = 1'b0;
        por_active  = 1'b1;
    end

    // ------------------------------------------------------------------
    // Link traffic
    // ------------------------------------------------------------------
    // Frame of n 80 ns periods; the clock stands high between frames
    task frame(input int n);
        swclk = 1'b1;
        repeat (n)
        begin
            #40 swclk = 1'b0;
            #40 swclk = 1'b1;
        end
    endtask

    // Reset cycle; sw_lvl is the clock level held across reset release
    task restart(input logic sw_lvl, input bit clk_in_rst, input bit por_too);
        @(posedge clk);
        ext_reset_n <= 1'b0;
        if (por_too)
            por_active <= 1'b1;
        repeat (4) @(posedge clk);
        // Edges here must be dropped by the device
        if (clk_in_rst)
            frame(4);
        @(posedge clk);
        por_active <= 1'b0;
        // Reset outlasts power-on reset, so no retry is needed
        repeat (4) @(posedge clk);
        swclk = sw_lvl;
        repeat (4) @(posedge clk);
        ext_reset_n <= 1'b1;
        // Clock stays idle well past release before any frame
        repeat (6) @(posedge clk);
        #1;
    endtask
endmodule

//--- debug_service_probe_security_test.sv
// Self-checking bench for the debug service logic.
// Assumes debug_adapter drives the reset and debug clock pins.
`timescale 1ns/10ps

module debug_service_probe_security_test
    import service_unit_pkg::*;
();
    logic       clk, reset, swclk, por_active, ext_reset_n;
    logic       nv, peripheral_access_controller, mux;
    logic [5:0] stb;     // wr_one, perr_clr, erase, ram/flash/lock ack
    svc_req_t   dq, cq;
    svc_resp_t  dr, cr;
    logic       cre, hold, perr, dp, hpe, done, rq, fq, lq;
    int         error_cnt, check_count;

    service_unit u_service_unit (
        .clk(clk), .reset(reset), .swclk(swclk), .por_active(por_active),
        .ext_reset_n(ext_reset_n), .swclk_mux_default(mux),
        .nv_protected(nv), .pac_write_protect(peripheral_access_controller),
        .cpu_reset_ext_wr_one(stb[0]), .perr_clr_one(stb[1]),
        .chip_erase_cmd(stb[2]), .ram_clear_ack(stb[3]),
        .flash_erase_ack(stb[4]), .lock_erase_ack(stb[5]),
        .dbg_req(dq), .cpu_req(cq), .cpu_reset_ext(cre), .cpu_hold(hold),
        .protection_error(perr), .debugger_present(dp),
        .hot_plug_enable(hpe), .done(done), .ram_clear_req(rq),
        .flash_erase_req(fq), .lock_erase_req(lq), .dbg_resp(dr), .cpu_resp(cr));

    debug_adapter u_debug_adapter (
        .clk(clk), .swclk(swclk), .ext_reset_n(ext_reset_n),
        .por_active(por_active));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_resp(input svc_resp_t got, input svc_resp_t exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle strobe; result is looked at just after the taking edge
    task pulse(input int i);
        @(posedge clk);
        stb[i] <= 1'b1;
        @(posedge clk);
        stb[i] <= 1'b0;
        #1;
    endtask

    // Same access on both ports, answer one cycle later
    task acc(input svc_req_t q, input svc_resp_t ed, input svc_resp_t ec);
        @(posedge clk);
        dq <= q;
        cq <= q;
        @(posedge clk);
        dq.valid <= 1'b0;
        cq.valid <= 1'b0;
        #1;
        chk_resp(dr, ed);
        chk_resp(cr, ec);
    endtask

    // Expected answer worked out from the address map
    function automatic svc_resp_t exp_r(svc_req_t q, bit d, bit p);
        exp_r.valid = 1'b1;
        exp_r.hit   = q.in_svc && q.addr <= EXT_RANGE_HI;
        exp_r.ext   = q.in_svc && q.addr >= EXT_RANGE_LO && q.addr <= EXT_RANGE_HI;
        exp_r.off   = q.addr[7:0];
        exp_r.error = d && p && !(q.in_svc && q.addr >= SVC_RANGE_LO
                      && q.addr < SVC_RANGE_HI);
    endfunction

    task print_verdict;
        $display("checks=%0d mismatches=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog
    // ------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Whole run is a few hundred cycles; this is far past it
    initial
    begin
        #3_000_000;
        error_cnt++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    logic [15:0] tbl [7] = '{16'h0050, 16'h00FF, 16'h0100, 16'h01FF,
                             16'h0200, 16'h1FFF, 16'h2000};
    svc_req_t q;
    initial
    begin
        reset = 1'b1;
        {nv, peripheral_access_controller, stb} = '0;
        mux = 1'b1;
        dq = '0;
        cq = '0;
        error_cnt = 0;
        check_count = 0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk({cre, dp, hold}, 3'b001);
        u_debug_adapter.restart(1'b0, 1'b0, 1'b1);
        chk({cre, dp, hold, hpe}, 4'b1111);
        $display("test cold_plug done");

        // Release refused while protected, then cleared
        @(posedge clk) nv <= 1'b1;
        pulse(0);
        chk({cre, perr}, 2'b11);
        @(posedge clk) nv <= 1'b0;
        pulse(1);
        chk({cre, perr}, 2'b10);
        pulse(0);
        chk({cre, hold}, 2'b00);
        @(posedge clk) nv <= 1'b1;
        pulse(0);
        chk({cre, perr}, 2'b00);
        @(posedge clk) nv <= 1'b0;
        $display("test reset_extension done");

        // Chip erase: refused under write protect, then three ordered steps
        @(posedge clk) peripheral_access_controller <= 1'b1;
        pulse(2);
        chk({done, lq, fq, rq}, 4'b0000);
        @(posedge clk) peripheral_access_controller <= 1'b0;
        pulse(2);
        for (int i = 0; i < 3; i++)
        begin
            chk({done, lq, fq, rq}, 4'(1 << i));
            pulse(3 + i);
        end
        chk({done, lq, fq, rq}, 4'b1000);
        $display("test chip_erase done");

        // Reset after erase with the clock high; edges in reset dropped
        u_debug_adapter.restart(1'b1, 1'b1, 1'b0);
        chk({cre, dp, hold}, 3'b000);
        u_debug_adapter.frame(1);
        repeat (6) @(posedge clk);
        #1;
        chk(dp, 1'b1);
        $display("test hot_plug done");

        // Protection and pin reassignment disable hot plug
        u_debug_adapter.restart(1'b1, 1'b0, 1'b0);
        @(posedge clk) nv <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(hpe, 1'b0);
        u_debug_adapter.frame(1);
        repeat (6) @(posedge clk);
        #1;
        chk(dp, 1'b0);
        @(posedge clk) nv <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(hpe, 1'b1);
        @(posedge clk) mux <= 1'b0;
        @(posedge clk) mux <= 1'b1;
        repeat (2) @(posedge clk);
        u_debug_adapter.frame(1);
        repeat (6) @(posedge clk);
        #1;
        chk({hpe, dp}, 2'b00);
        u_debug_adapter.restart(1'b1, 1'b0, 1'b0);
        chk(hpe, 1'b1);
        @(posedge clk) nv <= 1'b1;
        u_debug_adapter.restart(1'b0, 1'b0, 1'b0);
        chk({cre, dp, hold}, 3'b111);
        @(posedge clk) nv <= 1'b0;
        pulse(0);
        $display("test protection done");

        // Address filter, both ports, open and protected
        for (int p = 0; p < 2; p++)
        begin
            @(posedge clk) nv <= p[0];
            for (int i = 0; i < 8; i++)
            begin
                q = '{valid: 1'b1, in_svc: (i < 7), addr: tbl[i % 7]};
                acc(q, exp_r(q, 1, p[0]), exp_r(q, 0, p[0]));
            end
        end
        $display("test filter done");
        print_verdict();
    end
endmodule

//--- service_unit.sv
// Debug service logic: probe detection (cold and hot plug), CPU reset
// extension, chip erase sequencing and the debugger security filter.
// Assumes por_active, ext_reset_n and swclk are asynchronous pins; all other
// inputs come from logic on clk. swclk also clocks the hot-plug edge catcher.
//
// Functional notes
// - Reset release with debug clock low means a debugger; extend CPU reset.
// - cpu_reset_ext stays set; writing one clears it, zero does nothing.
// - Protected: release write refused, protection_error set instead.
// - Extended reset request at release counts as cold-plug detection.
// - Hot-plug detector held in reset during power-on or external reset.
// - Outside reset, a debug clock falling edge is a hot-plug detection.
// - Debug clock pin reassigned: hot plug off until next reset.
// - hot_plug_enable shows whether hot-plug detection is available.
// - debugger_present set after any cold- or hot-plug detection.
// - Protection disables hot plug; only cold plug remains.
// - No detection at cold start before power-on reset is released.
// - Writing one to chip_erase_cmd starts a chip erase.
// - Chip erase ignored while access controller write-protects registers.
// - Erase order: volatile memories, flash array, then lock row.
// - done reads one when erase finished; debugger polls it.
// - After cold plug the CPU stays in reset, the rest is released.
// - Protected: debugger accesses outside 0x0100-0x1FFF get an error.
// - Internal range 0x0000-0x00FF, mirrored external range 0x0100-0x01FF.
// - Protected: debugger transfers only accepted within 0x0100-0x1FFF.
// - CPU accesses have full access even when protected.
// - Protected: extension and cold plug still work, clearing refused.
`timescale 1ns/10ps

module service_unit
    import service_unit_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      reset,
    input  wire logic      swclk,
    input  wire logic      por_active,
    input  wire logic      ext_reset_n,
    input  wire logic      swclk_mux_default,
    input  wire logic      nv_protected,
    input  wire logic      pac_write_protect,
    input  wire logic      cpu_reset_ext_wr_one,
    input  wire logic      perr_clr_one,
    input  wire logic      chip_erase_cmd,
    input  wire logic      ram_clear_ack,
    input  wire logic      flash_erase_ack,
    input  wire logic      lock_erase_ack,
    input  wire svc_req_t  dbg_req,
    input  wire svc_req_t  cpu_req,
    output logic           cpu_reset_ext,
    output logic           cpu_hold,
    output logic           protection_error,
    output logic           debugger_present,
    output logic           hot_plug_enable,
    output logic           done,
    output logic           ram_clear_req,
    output logic           flash_erase_req,
    output logic           lock_erase_req,
    output svc_resp_t      dbg_resp,
    output svc_resp_t      cpu_resp
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic         por_s1;
        logic         por_s2;
        logic         rstn_s1;
        logic         rstn_s2;
        logic         swl_s1;
        logic         swl_s2;
        logic         fell_s1;
        logic         fell_s2;
        logic         in_rst;
        logic         mux_lost;
        logic         hot_arm;
        logic         cpu_reset_ext;
        logic         cpu_hold;
        logic         prot_err;
        logic         dbg_present;
        logic         hpe;
        erase_state_t er_state;
        logic         done;
        logic         ram_req;
        logic         flash_req;
        logic         lock_req;
        svc_resp_t    dbg_resp;
        svc_resp_t    cpu_resp;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic   fell_raw_reg;
    logic   sys_rst;
    logic   release_ev;
    logic   cold_plug;
    logic   hot_plug;
    logic   hpe_now;

    // ------------------------------------------------------------------
    // Address decode shared by both masters
    // ------------------------------------------------------------------
    function automatic svc_resp_t decode(input svc_req_t req);
        svc_resp_t r;
        r       = '0;
        r.valid = req.valid;
        r.hit   = req.in_svc && (req.addr <= EXT_RANGE_HI);
        r.ext   = req.in_svc && (req.addr >= EXT_RANGE_LO) && (req.addr <= EXT_RANGE_HI);
        r.off   = req.addr[REG_OFF_MSB:0];
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Hot-plug edge catcher on the link clock
    // ------------------------------------------------------------------
    // Sticky flag set on a falling swclk edge. The clock may stand still, so
    // it is cleared from the clk side through the armed level, not by swclk.
    always_ff @(negedge swclk or negedge state_reg.hot_arm)
    begin
        if (!state_reg.hot_arm)
            fell_raw_reg <= 1'b0;
        else
            fell_raw_reg <= 1'b1;
    end

    // ------------------------------------------------------------------
    // Combined reset level and detection events
    // ------------------------------------------------------------------
    // Power-on reset gates cold- and hot-plug detection, so nothing is seen before pads power up
    assign sys_rst    = state_reg.por_s2 || !state_reg.rstn_s2;
    assign release_ev = state_reg.in_rst && !sys_rst;
    assign cold_plug  = release_ev && !state_reg.swl_s2;
    assign hot_plug   = state_reg.hot_arm && state_reg.fell_s2;
    assign hpe_now    = !state_reg.mux_lost && swclk_mux_default && !nv_protected;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;

        // Pin synchronisers
        state_next.por_s1  = por_active;
        state_next.por_s2  = state_reg.por_s1;
        state_next.rstn_s1 = ext_reset_n;
        state_next.rstn_s2 = state_reg.rstn_s1;
        state_next.swl_s1  = swclk;
        state_next.swl_s2  = state_reg.swl_s1;
        // Stale edge flag is flushed whenever the catcher is disarmed
        state_next.fell_s1 = state_reg.hot_arm ? fell_raw_reg : 1'b0;
        state_next.fell_s2 = state_reg.hot_arm ? state_reg.fell_s1 : 1'b0;
        state_next.in_rst  = sys_rst;

        // Pin reassignment latches until the next power or external reset
        if (sys_rst)
            state_next.mux_lost = 1'b0;
        else
            state_next.mux_lost = state_reg.mux_lost || !swclk_mux_default;

        // Availability and arming follow protection directly
        state_next.hpe = !(sys_rst ? 1'b0 : (state_reg.mux_lost || !swclk_mux_default))
                         && !nv_protected;
        state_next.hot_arm = !sys_rst && hpe_now;

        // Presence flag: cleared by system reset, set by either detection
        if (sys_rst)
            state_next.dbg_present = 1'b0;
        else if (cold_plug || hot_plug)
            state_next.dbg_present = 1'b1;

        // Reset extension: release write refused while protected
        if (sys_rst)
            state_next.cpu_reset_ext = 1'b0;
        else if (cold_plug)
            state_next.cpu_reset_ext = 1'b1;
        else if (cpu_reset_ext_wr_one && !nv_protected)
            state_next.cpu_reset_ext = 1'b0;

        // Error flag; a new refusal wins over a clear in the same cycle
        if (cpu_reset_ext_wr_one && nv_protected && state_reg.cpu_reset_ext)
            state_next.prot_err = 1'b1;
        else if (perr_clr_one)
            state_next.prot_err = 1'b0;

        // CPU stays held while the rest of the system runs
        state_next.cpu_hold = sys_rst || state_next.cpu_reset_ext;

        // Chip erase sequencer
        case (state_reg.er_state)
            ER_IDLE:
            begin
                if (chip_erase_cmd && !pac_write_protect)
                begin
                    state_next.er_state = ER_RAM;
                    state_next.done     = 1'b0;
                    state_next.ram_req  = 1'b1;
                end
            end
            ER_RAM:
            begin
                if (ram_clear_ack)
                begin
                    state_next.er_state  = ER_FLASH;
                    state_next.ram_req   = 1'b0;
                    state_next.flash_req = 1'b1;
                end
            end
            ER_FLASH:
            begin
                if (flash_erase_ack)
                begin
                    state_next.er_state  = ER_LOCK;
                    state_next.flash_req = 1'b0;
                    state_next.lock_req  = 1'b1;
                end
            end
            ER_LOCK:
            begin
                if (lock_erase_ack)
                begin
                    state_next.er_state = ER_IDLE;
                    state_next.lock_req = 1'b0;
                    state_next.done     = 1'b1;
                end
            end
            default:
            begin
                state_next.er_state = ER_IDLE;
            end
        endcase

        // Debugger path filtered while protected
        state_next.dbg_resp = decode(dbg_req);
        state_next.dbg_resp.error = dbg_req.valid && nv_protected
            && !(dbg_req.in_svc && (dbg_req.addr >= SVC_RANGE_LO)
                 && (dbg_req.addr < SVC_RANGE_HI));

        // CPU path never filtered
        state_next.cpu_resp = decode(cpu_req);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg               <= '0;
            state_reg.por_s1        <= 1'b1;
            state_reg.por_s2        <= 1'b1;
            state_reg.in_rst        <= 1'b1;
            state_reg.cpu_hold      <= 1'b1;
            state_reg.cpu_reset_ext <= RST_CPU_RESET_EXT;
            state_reg.prot_err      <= RST_PROT_ERROR;
            state_reg.dbg_present   <= RST_DEBUGGER_PRESENT;
            state_reg.hpe           <= RST_HOT_PLUG_ENABLE;
            state_reg.done          <= RST_DONE;
            state_reg.er_state      <= ER_IDLE;
        end
        else
            state_reg <= state_next;
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------------
    assign cpu_reset_ext    = state_reg.cpu_reset_ext;
    assign cpu_hold         = state_reg.cpu_hold;
    assign protection_error = state_reg.prot_err;
    assign debugger_present = state_reg.dbg_present;
    assign hot_plug_enable  = state_reg.hpe;
    assign done             = state_reg.done;
    assign ram_clear_req    = state_reg.ram_req;
    assign flash_erase_req  = state_reg.flash_req;
    assign lock_erase_req   = state_reg.lock_req;
    assign dbg_resp         = state_reg.dbg_resp;
    assign cpu_resp         = state_reg.cpu_resp;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    cold_plug_a: assert property (cold_plug |=> cpu_reset_ext && debugger_present && cpu_hold)
        else $error("cold plug did not extend reset");

    ext_release_a: assert property (
        cpu_reset_ext && cpu_reset_ext_wr_one && !nv_protected && !sys_rst && !cold_plug
        |=> !cpu_reset_ext)
        else $error("extension not released by write");

    release_refused_a: assert property (
        cpu_reset_ext && cpu_reset_ext_wr_one && nv_protected && !sys_rst
        |=> cpu_reset_ext && protection_error)
        else $error("protected release not refused");

    hot_reset_a: assert property ((sys_rst || nv_protected) |=> !state_reg.hot_arm)
        else $error("hot plug armed in reset or protection");

    hot_plug_a: assert property (hot_plug && !sys_rst |=> debugger_present)
        else $error("hot plug not reported");

    // A system reset right after the reassignment may legally re-enable it
    mux_lost_a: assert property (!swclk_mux_default && !sys_rst
        |=> !hot_plug_enable ##1 (!hot_plug_enable || state_reg.in_rst))
        else $error("hot plug still enabled after pin reassignment");

    erase_ignore_a: assert property (
        chip_erase_cmd && pac_write_protect && state_reg.er_state == ER_IDLE
        |=> state_reg.er_state == ER_IDLE && !ram_clear_req)
        else $error("erase started while write protected");

    erase_order_a: assert property (
        ram_clear_req && ram_clear_ack |=> flash_erase_req && !ram_clear_req && !done)
        else $error("flash erase did not follow memory clear");

    erase_done_a: assert property (
        lock_erase_req && lock_erase_ack |=> done && !lock_erase_req
        ##1 (done || ram_clear_req))
        else $error("done not set after lock row erase");

    filter_a: assert property (
        dbg_req.valid && nv_protected && (!dbg_req.in_svc || dbg_req.addr < SVC_RANGE_LO)
        |=> dbg_resp.valid && dbg_resp.error)
        else $error("protected access outside range not refused");

    cpu_open_a: assert property (cpu_req.valid |=> cpu_resp.valid && !cpu_resp.error)
        else $error("cpu access refused");

    erase_start_a: assert property (
        chip_erase_cmd && !pac_write_protect && state_reg.er_state == ER_IDLE
        |=> ram_clear_req && !done)
        else $error("erase did not start on command");

    hpe_protect_a: assert property (nv_protected |=> !hot_plug_enable)
        else $error("hot plug shown available while protected");

    resp_idle_a: assert property (!dbg_req.valid |=> !dbg_resp.valid)
        else $error("debugger answer without a request");

endmodule

//--- service_unit_pkg.sv
// Package for the debug service logic: address map, reset values, carriers
// and the chip erase sequencer states.
// Assumes offsets are byte offsets relative to the service unit base.
package service_unit_pkg;

    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam logic [15:0] INT_RANGE_LO  = 16'h0000;
    localparam logic [15:0] INT_RANGE_HI  = 16'h00FF;
    localparam logic [15:0] EXT_RANGE_LO  = 16'h0100;
    localparam logic [15:0] EXT_RANGE_HI  = 16'h01FF;
    localparam logic [15:0] SVC_RANGE_LO  = 16'h0100;
    localparam logic [15:0] SVC_RANGE_HI  = 16'h2000;
    localparam int          REG_OFF_MSB   = 7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic RST_CPU_RESET_EXT    = 1'b0;
    localparam logic RST_PROT_ERROR       = 1'b0;
    localparam logic RST_DEBUGGER_PRESENT = 1'b0;
    localparam logic RST_HOT_PLUG_ENABLE  = 1'b0;
    localparam logic RST_DONE             = 1'b0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ER_IDLE, ER_RAM, ER_FLASH, ER_LOCK} erase_state_t;

    // Bus access seen by the filter or the decoder
    typedef struct packed {
        logic        valid;
        logic        in_svc;
        logic [15:0] addr;
    } svc_req_t;

    // One-cycle answer to an access
    typedef struct packed {
        logic        valid;
        logic        error;
        logic        hit;
        logic        ext;
        logic [7:0]  off;
    } svc_resp_t;

endpackage
